// file: slsd_consts.svh
// Offsets, field positions, word patterns and reset values of the link block.
`ifndef SLSD_CONSTS_SVH
`define SLSD_CONSTS_SVH

`define SLSD_NUM_PORTS      16
`define SLSD_WORD_BITS      34
`define SLSD_ERRCNT_WRAP    3'h7
`define SLSD_CDEL_BITS      4

`define SLSD_OVH_HI         33
`define SLSD_OVH_LO         32
`define SLSD_CMD_HI         28
`define SLSD_CMD_LO         24
`define SLSD_OVH_CMD        2'h0
`define SLSD_OVH_CELL       2'h3
`define SLSD_CMD_ALIGN      5'h00
`define SLSD_CMD_IDLE       5'h07

`define SLSD_ALIGN_BODY     32'h00AAAAAA
`define SLSD_IDLE_BODY      32'h07AAAAAA
`define SLSD_IDLE_MASK      32'hFF0000FF
`define SLSD_IDLE_EXPECT    32'h070000AA

`define SLSD_ADDR_BITS      6
`define SLSD_OFS_INT_STATUS 6'h00
`define SLSD_OFS_INT_CTRL   6'h04
`define SLSD_OFS_LINK_ERR   6'h08
`define SLSD_OFS_ERR_COUNT  6'h0C
`define SLSD_OFS_PHASE_ERR  6'h10
`define SLSD_OFS_CELL_ERR   6'h14
`define SLSD_OFS_CHAN_EN    6'h18
`define SLSD_OFS_RELINK     6'h1C
`define SLSD_OFS_LINK_STAT  6'h20
`define SLSD_OFS_CELL_DELAY 6'h24

`define SLSD_RST_INT_CTRL   8'h00
`define SLSD_RST_CHAN_EN    16'h0000
`define SLSD_RST_CELL_DELAY 4'h0

`endif

// file: slsd_pkg.sv
// Types shared by the link synchronisation and error block.
package slsd_pkg;

  typedef enum logic [0:0] {
    SLSD_ST_ALIGN,
    SLSD_ST_LINKED
  } slsd_state_type;

endpackage

// file: slsd_top.sv
// Per-port link synchronisation and link error detection with APB registers.
//
// Notes on behaviour
// - Lock indicator low until multiplier has locked.
// - All links start together; errors relink singly.
// - Bit, word, then cell sync; switch is master.
// - Words are 32 data plus 2 overhead.
// - Reset request word starts sending alignment words.
// - Keep sending alignment until aligned word arrives.
// - Aligned word seen, switch then sends idle.
// - Sync clears flags; alert high when all linked.
// - Cell clock delayed; embedded in alignment words.
// - Bad idle word sets link error flag.
// - Every eighth link error sets count flag.
// - Phase recovery out of range sets flag.
// - Cell-end idle without cell marker sets flag.
// - Flags raise alert or relink per enables.
// - Flags clear on relink or on read.
// - Auto relink pin relinks on any error.
// - Alignment command 00000, idle command 00111.
// - Idle words checked through a bit mask.
// - Cell error alert and relink enables.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "slsd_consts.svh"

module slsd_top #(
  parameter int NUM_PORTS = `SLSD_NUM_PORTS
) (
  input  wire logic                              clock_in,
  input  wire logic                              rst_n_in,
  input  wire logic                              psel_in,
  input  wire logic                              penable_in,
  input  wire logic                              pwrite_in,
  input  wire logic [31:0]                       paddr_in,
  input  wire logic [31:0]                       pwdata_in,
  output logic      [31:0]                       prdata_out,
  output logic                                   pready_out,
  output logic                                   pslverr_out,
  input  wire logic                              multiplier_locked_in,
  input  wire logic                              cell_mode_select_in,
  input  wire logic                              auto_relink_on_error_in,
  input  wire logic                              cell_boundary_clock_in,
  input  wire logic [NUM_PORTS-1:0]              phase_out_of_range_in,
  input  wire logic [NUM_PORTS-1:0][`SLSD_WORD_BITS-1:0] rx_word_in,
  output logic      [NUM_PORTS-1:0][`SLSD_WORD_BITS-1:0] tx_word_out,
  output logic      [NUM_PORTS-1:0]              link_up_out,
  output logic                                   pll_lock_indicator_out,
  output logic                                   alert_n_out
);

  initial
  begin
    if (NUM_PORTS < 1 || NUM_PORTS > 32)
      $error("NUM_PORTS must lie between 1 and 32.");
  end

  // Pin synchronisers; only the second stage is read by logic.
  logic [3:0]           pins_s1_q;
  logic [3:0]           pins_s2_q;
  logic [NUM_PORTS-1:0] phase_s1_q;
  logic [NUM_PORTS-1:0] phase_s2_q;
  logic                 cell_boundary_clock_prev_q;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      pins_s1_q   <= 4'h0;
      pins_s2_q   <= 4'h0;
      phase_s1_q  <= '0;
      phase_s2_q  <= '0;
      cell_boundary_clock_prev_q <= 1'b0;
    end
    else
    begin
      pins_s1_q   <= {cell_boundary_clock_in, auto_relink_on_error_in,
                      cell_mode_select_in, multiplier_locked_in};
      pins_s2_q   <= pins_s1_q;
      phase_s1_q  <= phase_out_of_range_in;
      phase_s2_q  <= phase_s1_q;
      cell_boundary_clock_prev_q <= pins_s2_q[3];
    end
  end

  wire lock_sync  = pins_s2_q[0];
  wire cell_mode  = pins_s2_q[1];
  wire auto_sync  = pins_s2_q[2];
  wire cell_tick  = pins_s2_q[3] & ~cell_boundary_clock_prev_q;

  assign pll_lock_indicator_out = lock_sync;

  // Registers.
  logic [7:0]                  int_ctrl_q;
  logic [NUM_PORTS-1:0]        chan_en_q;
  logic [`SLSD_CDEL_BITS-1:0]  cell_delay_q;
  logic [NUM_PORTS-1:0]        link_error_flags_q;
  logic [NUM_PORTS-1:0]        error_count_flags_q;
  logic [NUM_PORTS-1:0]        phase_range_error_flags_q;
  logic [NUM_PORTS-1:0]        cell_boundary_error_flags_q;
  logic [NUM_PORTS-1:0]        linked;
  logic [14:0]                 tick_dly_q;
  logic                        ready_q;
  logic [31:0]                 prdata_q;
  logic                        alert_n_q;

  // Cell clock is delayed so that looped cells line up with the master
  // clock; zero delay uses the undelayed edge.
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      tick_dly_q <= 15'h0000;
    else
      tick_dly_q <= {tick_dly_q[13:0], cell_tick};
  end

  wire cell_end = (cell_delay_q == 4'h0) ? cell_tick
                  : tick_dly_q[cell_delay_q - 4'h1];

  // APB slave: one wait state so that read data comes from a flip-flop.
  wire [`SLSD_ADDR_BITS-1:0] addr = paddr_in[`SLSD_ADDR_BITS-1:0];
  wire in_range  = (paddr_in[31:`SLSD_ADDR_BITS] == '0);
  wire hit_isr   = in_range && addr == `SLSD_OFS_INT_STATUS;
  wire hit_ictl  = in_range && addr == `SLSD_OFS_INT_CTRL;
  wire hit_link_error_flags  = in_range && addr == `SLSD_OFS_LINK_ERR;
  wire hit_error_count_flags  = in_range && addr == `SLSD_OFS_ERR_COUNT;
  wire hit_phase_range_error_flags  = in_range && addr == `SLSD_OFS_PHASE_ERR;
  wire hit_cell_boundary_error_flags  = in_range && addr == `SLSD_OFS_CELL_ERR;
  wire hit_chen  = in_range && addr == `SLSD_OFS_CHAN_EN;
  wire hit_rel   = in_range && addr == `SLSD_OFS_RELINK;
  wire hit_stat  = in_range && addr == `SLSD_OFS_LINK_STAT;
  wire hit_cdel  = in_range && addr == `SLSD_OFS_CELL_DELAY;
  wire hit_any   = hit_isr | hit_ictl | hit_link_error_flags | hit_error_count_flags | hit_phase_range_error_flags
                   | hit_cell_boundary_error_flags | hit_chen | hit_rel | hit_stat | hit_cdel;
  wire access    = psel_in & penable_in;
  wire done      = access & ready_q;
  wire wr_done   = done & pwrite_in;
  wire rd_done   = done & ~pwrite_in;
  wire clr_link_error_flags  = rd_done & hit_link_error_flags;
  wire clr_error_count_flags  = rd_done & hit_error_count_flags;
  wire clr_phase_range_error_flags  = rd_done & hit_phase_range_error_flags;
  wire clr_cell_boundary_error_flags  = rd_done & hit_cell_boundary_error_flags;
  wire [NUM_PORTS-1:0] relink_wr = (wr_done & hit_rel)
                                   ? pwdata_in[NUM_PORTS-1:0] : '0;

  wire [3:0] isr = {|cell_boundary_error_flags_q, |phase_range_error_flags_q, |error_count_flags_q, |link_error_flags_q};

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (hit_isr)  rd_mux[3:0] = isr;
    if (hit_ictl) rd_mux[7:0] = int_ctrl_q;
    if (hit_link_error_flags) rd_mux[NUM_PORTS-1:0] = link_error_flags_q;
    if (hit_error_count_flags) rd_mux[NUM_PORTS-1:0] = error_count_flags_q;
    if (hit_phase_range_error_flags) rd_mux[NUM_PORTS-1:0] = phase_range_error_flags_q;
    if (hit_cell_boundary_error_flags) rd_mux[NUM_PORTS-1:0] = cell_boundary_error_flags_q;
    if (hit_chen) rd_mux[NUM_PORTS-1:0] = chan_en_q;
    if (hit_stat) rd_mux[NUM_PORTS-1:0] = linked;
    if (hit_cdel) rd_mux[`SLSD_CDEL_BITS-1:0] = cell_delay_q;
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      ready_q      <= 1'b0;
      prdata_q     <= 32'h00000000;
      int_ctrl_q   <= `SLSD_RST_INT_CTRL;
      chan_en_q    <= '0;
      cell_delay_q <= `SLSD_RST_CELL_DELAY;
    end
    else
    begin
      ready_q <= access & ~ready_q;
      if (access & ~ready_q)
        prdata_q <= rd_mux;
      if (wr_done & hit_ictl)
        int_ctrl_q <= pwdata_in[7:0];
      if (wr_done & hit_chen)
        chan_en_q <= pwdata_in[NUM_PORTS-1:0];
      if (wr_done & hit_cdel)
        cell_delay_q <= pwdata_in[`SLSD_CDEL_BITS-1:0];
    end
  end

  assign pready_out  = ready_q;
  assign pslverr_out = ready_q & ~hit_any;
  assign prdata_out  = prdata_q;

  // Interrupt control bits: relink enables high nibble, alert enables low.
  wire [3:0] alert_en  = int_ctrl_q[3:0];
  wire [3:0] relink_en = int_ctrl_q[7:4];

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++)
    begin : gen_port
      slsd_pkg::slsd_state_type state_q;
      logic [2:0]                 errcnt_q;
      logic [`SLSD_WORD_BITS-1:0] tx_q;

      wire [`SLSD_WORD_BITS-1:0] rxw = rx_word_in[g];
      wire [1:0] ovh = rxw[`SLSD_OVH_HI:`SLSD_OVH_LO];
      wire [4:0] cmd = rxw[`SLSD_CMD_HI:`SLSD_CMD_LO];
      wire is_linked = (state_q == slsd_pkg::SLSD_ST_LINKED);
      wire is_idle   = (cmd == `SLSD_CMD_IDLE);
      wire is_align  = (ovh == `SLSD_OVH_CMD)
                       && (rxw[31:0] == `SLSD_ALIGN_BODY);
      wire is_reqst  = (ovh == `SLSD_OVH_CELL)
                       && (cmd == `SLSD_CMD_ALIGN);
      wire link_error_flags_ev   = is_linked && is_idle && ((rxw[31:0] & `SLSD_IDLE_MASK)
                       != `SLSD_IDLE_EXPECT);
      wire error_count_flags_ev   = link_error_flags_ev && (errcnt_q == `SLSD_ERRCNT_WRAP);
      wire phase_range_error_flags_ev   = is_linked && phase_s2_q[g];
      wire cell_boundary_error_flags_ev   = is_linked && cell_mode && cell_end && is_idle
                       && (ovh != `SLSD_OVH_CELL);
      wire [3:0] evs   = {cell_boundary_error_flags_ev, phase_range_error_flags_ev, error_count_flags_ev, link_error_flags_ev};
      wire [3:0] flags = {cell_boundary_error_flags_q[g], phase_range_error_flags_q[g], error_count_flags_q[g], link_error_flags_q[g]};
      wire relink = relink_wr[g]
                    | (auto_sync & (|evs))
                    | (|(flags & relink_en));
      wire restart = relink | is_reqst;
      wire success = !is_linked && is_align && !restart;
      wire clr_all = restart | success;

      always_ff @(posedge clock_in)
      begin
        if (!rst_n_in)
        begin
          state_q   <= slsd_pkg::SLSD_ST_ALIGN;
          errcnt_q  <= 3'h0;
          tx_q      <= {`SLSD_OVH_CMD, `SLSD_ALIGN_BODY};
          link_error_flags_q[g] <= 1'b0;
          error_count_flags_q[g] <= 1'b0;
          phase_range_error_flags_q[g] <= 1'b0;
          cell_boundary_error_flags_q[g] <= 1'b0;
        end
        else
        begin
          case (state_q)
            slsd_pkg::SLSD_ST_ALIGN:
              if (success)
                state_q <= slsd_pkg::SLSD_ST_LINKED;
            slsd_pkg::SLSD_ST_LINKED:
              if (restart)
                state_q <= slsd_pkg::SLSD_ST_ALIGN;
            default:
              state_q <= slsd_pkg::SLSD_ST_ALIGN;
          endcase
          if (clr_all)
            errcnt_q <= 3'h0;
          else if (link_error_flags_ev)
            errcnt_q <= errcnt_q + 3'h1;
          // Set beats clear so an error in the clearing cycle survives.
          link_error_flags_q[g] <= link_error_flags_ev | (link_error_flags_q[g] & ~clr_link_error_flags & ~clr_all);
          error_count_flags_q[g] <= error_count_flags_ev | (error_count_flags_q[g] & ~clr_error_count_flags & ~clr_all);
          phase_range_error_flags_q[g] <= phase_range_error_flags_ev | (phase_range_error_flags_q[g] & ~clr_phase_range_error_flags & ~clr_all);
          cell_boundary_error_flags_q[g] <= cell_boundary_error_flags_ev | (cell_boundary_error_flags_q[g] & ~clr_cell_boundary_error_flags & ~clr_all);
          if (success || (is_linked && !restart))
            tx_q <= {`SLSD_OVH_CMD, `SLSD_IDLE_BODY};
          else if (cell_mode && cell_end)
            tx_q <= {`SLSD_OVH_CELL, `SLSD_ALIGN_BODY};
          else
            tx_q <= {`SLSD_OVH_CMD, `SLSD_ALIGN_BODY};
        end
      end

      assign linked[g]      = is_linked;
      assign tx_word_out[g] = tx_q;
    end
  endgenerate

  assign link_up_out = linked;

  // Alert stays low while an enabled channel is still initialising.
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      alert_n_q <= 1'b1;
    else
      alert_n_q <= ~((|(isr & alert_en))
                     | (|(chan_en_q & ~linked)));
  end

  assign alert_n_out = alert_n_q;

endmodule
`default_nettype wire

// file: slsd_top_asserts.sv
// Port-level assertions for the link synchronisation block.
`timescale 1ns/100ps
`default_nettype none
`include "slsd_consts.svh"
module slsd_top_asserts #(
  parameter int NUM_PORTS = 16
) (
  input wire logic                       clock_in,
  input wire logic                       rst_n_in,
  input wire logic                       psel_in,
  input wire logic                       penable_in,
  input wire logic [31:0]                paddr_in,
  input wire logic                       pready_out,
  input wire logic                       pslverr_out,
  input wire logic                       multiplier_locked_in,
  input wire logic                       pll_lock_indicator_out,
  input wire logic [NUM_PORTS-1:0][33:0] rx_word_in,
  input wire logic [NUM_PORTS-1:0][33:0] tx_word_out,
  input wire logic [NUM_PORTS-1:0]       link_up_out
);
  logic        hit;
  logic [33:0] rx0;
  assign hit = paddr_in[31:6] == 26'h0 && paddr_in[1:0] == 2'h0
    && paddr_in[5:2] <= 4'h9;
  assign rx0 = rx_word_in[0];
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_pready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  chk_pready_wait: assert property
    (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready missing after wait state");
  chk_slverr_map: assert property (pready_out |-> pslverr_out == !hit)
    else $error("pslverr does not match address");
  chk_lock_low: assert property
    (!multiplier_locked_in [*3] |=> !pll_lock_indicator_out)
    else $error("lock shown without lock");
  chk_align_links: assert property
    (!link_up_out[0] && rx0 == {`SLSD_OVH_CMD, `SLSD_ALIGN_BODY}
     |=> link_up_out[0])
    else $error("aligned word did not link");
  chk_tx_align: assert property
    (!link_up_out[0] |-> tx_word_out[0][31:0] == `SLSD_ALIGN_BODY)
    else $error("unlinked port not sending align");
  chk_tx_idle: assert property
    (link_up_out[0] |-> tx_word_out[0] == {`SLSD_OVH_CMD, `SLSD_IDLE_BODY})
    else $error("linked port not sending idle");
  chk_reset_req: assert property
    (rx0[33:32] == `SLSD_OVH_CELL && rx0[28:24] == `SLSD_CMD_ALIGN
     |=> !link_up_out[0])
    else $error("reset request ignored");
  cover property (pready_out && pslverr_out);
  cover property ($rose(link_up_out[0]));
  cover property ($fell(link_up_out[0]));
endmodule
bind slsd_top slsd_top_asserts #(.NUM_PORTS(NUM_PORTS)) i_slsd_top_asserts (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .multiplier_locked_in(multiplier_locked_in),
  .pll_lock_indicator_out(pll_lock_indicator_out),
  .rx_word_in(rx_word_in), .tx_word_out(tx_word_out),
  .link_up_out(link_up_out)
);
`default_nettype wire

// file: slsd_xcvr_model.sv
// Behavioural transceiver facing one switch port.
`timescale 1ns/100ps
`default_nettype none
`include "slsd_consts.svh"
module slsd_xcvr_model (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        restart_in,
  input  wire logic        bad_idle_in,
  input  wire logic        slow_in,
  input  wire logic [33:0] from_switch_in,
  output logic      [33:0] to_switch_out
);
  logic [1:0]  phase_q;
  logic [5:0]  tries_q;
  logic        sw_align;
  logic [33:0] al_w;
  assign sw_align = from_switch_in[31:0] == `SLSD_ALIGN_BODY;
  assign al_w = {`SLSD_OVH_CMD, `SLSD_ALIGN_BODY};
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in || restart_in)
    begin
      phase_q <= 2'h0;
      tries_q <= 6'h00;
    end
    else if (sw_align && phase_q == 2'h1)
      tries_q <= tries_q + {5'h00, !tries_q[5]};
    else if (sw_align)
    begin
      phase_q <= 2'h1;
      tries_q <= 6'h00;
    end
    else if (phase_q == 2'h1)
      phase_q <= 2'h2;
  end
  // A slow partner is one bit off until 32 words have gone by.
  always_comb
  begin
    if (phase_q == 2'h0)
      to_switch_out = {`SLSD_OVH_CELL, `SLSD_ALIGN_BODY};
    else if (phase_q == 2'h1 && slow_in && !tries_q[5])
      to_switch_out = {al_w[0], al_w[33:1]};
    else if (phase_q == 2'h1)
      to_switch_out = al_w;
    else
      to_switch_out = {`SLSD_OVH_CMD,
        `SLSD_IDLE_BODY ^ {24'h0, {8{bad_idle_in}}}};
  end
endmodule
`default_nettype wire

// file: slsd_top_tb.sv
// Self-checking bench for the link synchronisation block.
`timescale 1ns/100ps
`default_nettype none
`include "slsd_consts.svh"
module slsd_top_tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        locked, cell_mode_select, auto_rl, cell_boundary_clock, lock_ind, alert_n;
  logic        restart, bad, slow;
  logic [31:0] paddr, pwdata, prdata;
  logic [15:0] phase_oor, link_up;
  logic [15:0][33:0] tx;
  wire logic [15:0][33:0] rx;
  int          miscompares, comparisons;
  slsd_top i_slsd_top (
    .clock_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .multiplier_locked_in(locked), .cell_mode_select_in(cell_mode_select),
    .auto_relink_on_error_in(auto_rl), .cell_boundary_clock_in(cell_boundary_clock),
    .phase_out_of_range_in(phase_oor), .rx_word_in(rx), .tx_word_out(tx),
    .link_up_out(link_up), .pll_lock_indicator_out(lock_ind),
    .alert_n_out(alert_n));
  slsd_xcvr_model i_slsd_xcvr_model (
    .clock_in(clk), .rst_n_in(rst_n), .restart_in(restart),
    .bad_idle_in(bad), .slow_in(slow), .from_switch_in(tx[0]),
    .to_switch_out(rx[0]));
  for (genvar p = 1; p < 16; p++)
  begin : g_far
    assign rx[p] = {`SLSD_OVH_CMD, `SLSD_ALIGN_BODY};
  end
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    cell_boundary_clock = 1'b0;
    #7;
    forever #80 cell_boundary_clock = ~cell_boundary_clock;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a, e);
    logic [31:0] r;
    logic        er;
    xfer(1'b0, a, 32'h0, r, er);
    chk($sformatf("reg %h", a), r, e);
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    logic        er;
    xfer(1'b1, a, d, r, er);
  endtask
  task automatic inject;
    bad <= 1'b1;
    @(posedge clk);
    bad <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_link(input logic v);
    int n;
    n = 0;
    while (link_up[0] !== v && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk("link_up0", {31'h0, link_up[0]}, {31'h0, v});
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  initial
  begin : main
    logic [31:0] r;
    logic        er;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rst_n, locked, cell_mode_select, auto_rl, restart, bad} = '0;
    phase_oor = 16'h0000;
    slow = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("lock", {31'h0, lock_ind}, 32'h0);
    locked <= 1'b1;
    foreach (r[i])
      if (i < 10)
        rd(i * 4, (i == 8) ? 32'h0000FFFE : 32'h0);
    xfer(1'b0, 32'h28, 32'h0, r, er);
    chk("slverr", {er, r[30:0]}, 32'h80000000);
    chk("lock", {31'h0, lock_ind}, 32'h1);
    wait_link(1'b1);
    chk("links", {16'h0, link_up}, 32'hFFFF);
    wr(`SLSD_OFS_CHAN_EN, 32'hFFFF);
    chk("alert", {31'h0, alert_n}, 32'h1);
    repeat (7) inject();
    rd(`SLSD_OFS_ERR_COUNT, 32'h0);
    inject();
    rd(`SLSD_OFS_INT_STATUS, 32'h3);
    rd(`SLSD_OFS_ERR_COUNT, 32'h1);
    rd(`SLSD_OFS_LINK_ERR, 32'h1);
    rd(`SLSD_OFS_LINK_ERR, 32'h0);
    wr(`SLSD_OFS_INT_CTRL, 32'h01);
    inject();
    @(posedge clk);
    chk("alert", {31'h0, alert_n}, 32'h0);
    rd(`SLSD_OFS_LINK_ERR, 32'h1);
    @(posedge clk);
    chk("alert", {31'h0, alert_n}, 32'h1);
    wr(`SLSD_OFS_INT_CTRL, 32'h10);
    inject();
    wait_link(1'b0);
    chk("others", {17'h0, link_up[15:1]}, 32'h7FFF);
    wait_link(1'b1);
    wr(`SLSD_OFS_INT_CTRL, 32'h00);
    rd(`SLSD_OFS_LINK_ERR, 32'h0);
    auto_rl <= 1'b1;
    repeat (3) @(posedge clk);
    inject();
    wait_link(1'b0);
    wait_link(1'b1);
    auto_rl <= 1'b0;
    wr(`SLSD_OFS_RELINK, 32'h1);
    wait_link(1'b0);
    wait_link(1'b1);
    rd(`SLSD_OFS_RELINK, 32'h0);
    phase_oor <= 16'h0008;
    repeat (6) @(posedge clk);
    phase_oor <= 16'h0000;
    rd(`SLSD_OFS_PHASE_ERR, 32'h8);
    cell_mode_select <= 1'b1;
    wr(`SLSD_OFS_INT_CTRL, 32'h08);
    repeat (40) @(posedge clk);
    chk("alert", {31'h0, alert_n}, 32'h0);
    rd(`SLSD_OFS_CELL_ERR, 32'h1);
    cell_mode_select <= 1'b0;
    wr(`SLSD_OFS_INT_CTRL, 32'h00);
    xfer(1'b0, `SLSD_OFS_CELL_ERR, 32'h0, r, er);
    rd(`SLSD_OFS_CELL_ERR, 32'h0);
    slow <= 1'b0;
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    repeat (10) @(posedge clk);
    chk("links", {16'h0, link_up}, 32'hFFFF);
    report_and_stop();
  end
endmodule
`default_nettype wire
